// ### slcd_controller.sv
`timescale 1ns/1ps
module slcd_controller #(
  parameter int unsigned AUX_TIMEOUT_CYC = slcd_pkg::AUX_TIMEOUT_CYC_DFLT
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire slcd_pkg::slcd_bus_s   bus,
  input  wire logic                  halt_exec,
  input  wire logic                  wake_evt,
  input  wire logic                  aux_low_freq_osc,
  output logic      [7:0]            cpu_rdata,
  output slcd_pkg::slcd_panel_s      panel
);
  slcd_pkg::slcd_mode_s  mode_r;
  slcd_pkg::slcd_mode_s  act_r;
  slcd_pkg::slcd_state_e state_r;
  slcd_pkg::slcd_state_e state_nxt;
  logic                  halted_r;
  logic                  aux_s1_r, aux_s2_r, aux_s3_r;
  logic [8:0]            mdiv_cnt_r;
  logic [9:0]            frm_cnt_r;
  logic [1:0]            bp_idx_r;
  logic [1:0]            bp_next;
  logic [slcd_pkg::SEG_W-1:0] seg_r;
  logic [slcd_pkg::SEG_W-1:0] row_q;
  logic                  invert_r;
  logic [slcd_pkg::IDLE_W-1:0] idle_r;
  logic                  rd_ram_r, rd_mode_r;
  logic [7:0]            mode_q_r;
  logic [7:0]            ram_q;
  logic                  ram_hit, mode_hit;
  logic [4:0]            ram_idx;
  logic                  aux_rise, src_main, cfg_ok, main_tick, ref_tick, base_tick, frame_end, aux_lost;
  logic [8:0]            mdiv;
  logic [9:0]            fdiv;
  logic [1:0]            last_bp;
  logic [8:0]            tick_gap_r;
  logic                  gap_valid_r;

  // CPU access decode
  assign ram_hit  = (bus.addr >= slcd_pkg::ADDR_RAM_LO) && (bus.addr <= slcd_pkg::ADDR_RAM_HI);
  assign mode_hit = bus.addr == slcd_pkg::ADDR_MODE;
  assign ram_idx  = 5'(bus.addr - slcd_pkg::ADDR_RAM_LO);

  always_ff @(posedge clk)
  begin
    if (reset)
      mode_r <= slcd_pkg::slcd_mode_s'(slcd_pkg::MODE_RESET);
    else if (bus.wr && mode_hit)
      mode_r <= slcd_pkg::slcd_mode_s'(bus.wdata);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_ram_r  <= 1'b0;
      rd_mode_r <= 1'b0;
      mode_q_r  <= 8'h00;
    end
    else
    begin
      rd_ram_r  <= bus.rd && ram_hit;
      rd_mode_r <= bus.rd && mode_hit;
      mode_q_r  <= mode_r;
    end
  end

  // Unmapped reads return zero
  assign cpu_rdata = rd_ram_r ? ram_q : (rd_mode_r ? mode_q_r : 8'h00);

  slcd_pattern_ram u_ram (
    .clk     (clk),
    .wr_en   (bus.wr && ram_hit),
    .cpu_idx (ram_idx),
    .wdata   (bus.wdata),
    .cpu_q_r (ram_q),
    .row_sel (bp_next),
    .row_q_r (row_q)
  );

  // Auxiliary oscillator pin is asynchronous to clk
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      aux_s1_r <= 1'b0;
      aux_s2_r <= 1'b0;
      aux_s3_r <= 1'b0;
    end
    else
    begin
      aux_s1_r <= aux_low_freq_osc;
      aux_s2_r <= aux_s1_r;
      aux_s3_r <= aux_s2_r;
    end
  end
  assign aux_rise = aux_s2_r && !aux_s3_r;

  // Halt holds until the wake event; a halt in the same cycle wins
  always_ff @(posedge clk)
  begin
    if (reset)
      halted_r <= 1'b0;
    else if (halt_exec)
      halted_r <= 1'b1;
    else if (wake_evt)
      halted_r <= 1'b0;
  end

  always_comb
  begin
    unique case (act_r.src)
      slcd_pkg::SRC_DIV32:  mdiv = slcd_pkg::MDIV_32;
      slcd_pkg::SRC_DIV64:  mdiv = slcd_pkg::MDIV_64;
      slcd_pkg::SRC_DIV128: mdiv = slcd_pkg::MDIV_128;
      default:              mdiv = slcd_pkg::MDIV_256;
    endcase
    unique case (act_r.frm)
      3'h0:    fdiv = slcd_pkg::FDIV_512;
      3'h1:    fdiv = slcd_pkg::FDIV_386;
      3'h2:    fdiv = slcd_pkg::FDIV_256;
      3'h3:    fdiv = slcd_pkg::FDIV_192;
      3'h4:    fdiv = slcd_pkg::FDIV_128;
      3'h5:    fdiv = slcd_pkg::FDIV_96;
      default: fdiv = slcd_pkg::FDIV_64;
    endcase
    unique case (act_r.mux)
      slcd_pkg::MUX_1: last_bp = 2'h0;
      slcd_pkg::MUX_2: last_bp = 2'h1;
      slcd_pkg::MUX_3: last_bp = 2'h2;
      default:         last_bp = 2'h3;
    endcase
  end

  assign src_main = (act_r.src >= slcd_pkg::SRC_DIV32) && (act_r.src <= slcd_pkg::SRC_DIV256);
  // Reserved source or frame codes keep the display dark
  assign cfg_ok   = (src_main || act_r.src == slcd_pkg::SRC_AUX) && act_r.frm != slcd_pkg::FRM_RSV;

  // Main clock is gone in halt, so its divider stops
  always_ff @(posedge clk)
  begin
    if (reset || !src_main || halted_r)
      mdiv_cnt_r <= 9'h000;
    else if (mdiv_cnt_r == mdiv - 9'h001)
      mdiv_cnt_r <= 9'h000;
    else
      mdiv_cnt_r <= mdiv_cnt_r + 9'h001;
  end
  assign main_tick = src_main && !halted_r && (mdiv_cnt_r == mdiv - 9'h001);
  assign ref_tick  = (act_r.src == slcd_pkg::SRC_AUX) ? aux_rise : main_tick;

  // Spacing of main ticks, only trusted after one full undisturbed period
  always_ff @(posedge clk)
  begin
    if (reset || !src_main || halted_r)
    begin
      tick_gap_r  <= 9'h000;
      gap_valid_r <= 1'b0;
    end
    else if (main_tick)
    begin
      tick_gap_r  <= 9'h001;
      gap_valid_r <= 1'b1;
    end
    else
      tick_gap_r <= tick_gap_r + 9'h001;
  end

  // Missing auxiliary edges count as a failed source
  always_ff @(posedge clk)
  begin
    if (reset || aux_rise || act_r.src != slcd_pkg::SRC_AUX)
      idle_r <= '0;
    else if (idle_r != {slcd_pkg::IDLE_W{1'b1}})
      idle_r <= idle_r + 1'b1;
  end
  assign aux_lost = idle_r >= slcd_pkg::IDLE_W'(AUX_TIMEOUT_CYC);

  assign base_tick = state_r == slcd_pkg::ST_RUN && ref_tick && (frm_cnt_r == fdiv - 10'h001);
  assign frame_end = base_tick && (bp_idx_r == last_bp);
  assign bp_next   = (bp_idx_r == last_bp) ? 2'h0 : bp_idx_r + 2'h1;

  // New settings wait for the frame boundary; an idle controller takes them at once
  always_ff @(posedge clk)
  begin
    if (reset)
      act_r <= slcd_pkg::slcd_mode_s'(slcd_pkg::MODE_RESET);
    else if (frame_end || state_r != slcd_pkg::ST_RUN)
      act_r <= mode_r;
  end

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      slcd_pkg::ST_OFF:
        if (cfg_ok && !halted_r)
          state_nxt = slcd_pkg::ST_RUN;
      slcd_pkg::ST_RUN:
        if (!cfg_ok || (halted_r && act_r.src != slcd_pkg::SRC_AUX))
          state_nxt = slcd_pkg::ST_OFF;
        else if (act_r.src == slcd_pkg::SRC_AUX && aux_lost)
          state_nxt = slcd_pkg::ST_FAIL;
      slcd_pkg::ST_FAIL:
        if (act_r.src != slcd_pkg::SRC_AUX)
          state_nxt = slcd_pkg::ST_OFF;
        else if (aux_rise)
          state_nxt = slcd_pkg::ST_RUN;
      default:
        state_nxt = slcd_pkg::ST_OFF;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state_r <= slcd_pkg::ST_OFF;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_r != slcd_pkg::ST_RUN)
      frm_cnt_r <= 10'h000;
    else if (ref_tick)
      frm_cnt_r <= (frm_cnt_r == fdiv - 10'h001) ? 10'h000 : frm_cnt_r + 10'h001;
  end

  // Segment row is latched as each backplane slot opens
  always_ff @(posedge clk)
  begin
    if (reset || state_r != slcd_pkg::ST_RUN)
    begin
      bp_idx_r <= 2'h0;
      seg_r    <= '0;
      invert_r <= 1'b0;
    end
    else if (base_tick)
    begin
      bp_idx_r <= bp_next;
      seg_r    <= row_q;
      if (frame_end)
        invert_r <= !invert_r;
    end
  end

  // Everything grounded unless running
  always_comb
  begin
    panel = '0;
    if (state_r == slcd_pkg::ST_RUN)
    begin
      panel.on     = 1'b1;
      panel.seg    = seg_r;
      panel.bp     = 4'h1 << bp_idx_r;
      panel.invert = invert_r;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  chk_dark_ground:    assert property (state_r != slcd_pkg::ST_RUN |-> panel == '0)
    else $error("panel not grounded while off");
  chk_halt_main_off:  assert property (halted_r && src_main && state_r == slcd_pkg::ST_RUN |=> !panel.on)
    else $error("main clock display survived halt");
  chk_halt_pend_off:  assert property (halt_exec && act_r.src != slcd_pkg::SRC_AUX && cfg_ok
                                       ##1 state_r == slcd_pkg::ST_RUN |=> !panel.on)
    else $error("pending aux switch did not blank on halt");
  chk_aux_refresh:    assert property (halted_r && act_r.src == slcd_pkg::SRC_AUX && cfg_ok && !aux_lost
                                       && state_r == slcd_pkg::ST_RUN |=> panel.on)
    else $error("aux display stopped in halt");
  chk_cfg_hold:       assert property (state_r == slcd_pkg::ST_RUN && !frame_end |=> $stable(act_r))
    else $error("mode applied mid frame");
  chk_bp_scan:        assert property (panel.on |-> $onehot(panel.bp) && bp_idx_r <= last_bp)
    else $error("backplane outside mux ratio");
  chk_seg_latch:      assert property (base_tick |=> panel.seg == $past(row_q))
    else $error("segment row not latched");
  chk_main_div:       assert property (main_tick && gap_valid_r |-> tick_gap_r == mdiv)
    else $error("main divider wrong");
  chk_aux_fail:       assert property (state_r == slcd_pkg::ST_RUN && act_r.src == slcd_pkg::SRC_AUX
                                       && aux_lost && cfg_ok |=> !panel.on)
    else $error("lost aux clock not grounded");
  chk_frame_wrap:     assert property (frame_end |=> bp_idx_r == 2'h0 && invert_r != $past(invert_r))
    else $error("frame wrap wrong");

  cov_halt_aux:  cover property (halted_r && act_r.src == slcd_pkg::SRC_AUX && base_tick);
  cov_frame_end: cover property (frame_end && last_bp == 2'h3);
  cov_fail:      cover property (state_r == slcd_pkg::ST_FAIL);
endmodule // slcd_controller

// ### slcd_controller_note_unused.sv
`timescale 1ns/1ps

// ### slcd_controller_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module slcd_controller_tb;
  localparam int          SLOT = 2048; // 64 ticks of 32 clocks
  localparam logic [47:0] MASK = 48'hFFFF_FFFF_FFF8;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  slcd_pkg::slcd_bus_s    bus = '0;
  logic                   halt_exec = 1'b0;
  logic                   wake_evt = 1'b0;
  logic                   aux_low_freq_osc = 1'b0;
  logic                   aux_run = 1'b0;
  logic                   clr = 1'b1;
  logic [7:0]             cpu_rdata;
  slcd_pkg::slcd_panel_s  panel;
  logic [3:0][47:0]       lit;
  logic [3:0]             seen;
  int                     faults;
  int                     mismatches = 0;
  int                     n_checks = 0;
  int                     cyc = 0;
  int                     ram_m [24];
  int                     mode_m = slcd_pkg::MODE_RESET;
  logic [7:0]             codes [3] = '{8'h56, 8'h7E, 8'h5F};

  always #10 clk = ~clk;
  // Roughly 40 clocks a period, phase drifting against clk; still when stopped
  always #397 if (aux_run) aux_low_freq_osc = ~aux_low_freq_osc;

  slcd_controller #(.AUX_TIMEOUT_CYC(200)) slcd_controller_inst (.clk(clk), .reset(reset), .bus(bus),
    .halt_exec(halt_exec), .wake_evt(wake_evt), .aux_low_freq_osc(aux_low_freq_osc), .cpu_rdata(cpu_rdata),
    .panel(panel));
  slcd_panel_model slcd_panel_model_inst (.clk(clk), .panel(panel), .clr(clr), .lit(lit), .seen(seen),
    .faults(faults));

  task automatic wrap_up;
    if (mismatches == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 95000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = 1'b1;
    idle(1);
    bus.wr = 1'b0;
    if (a == slcd_pkg::ADDR_MODE) mode_m = d;
    else if (a >= slcd_pkg::ADDR_RAM_LO && a <= slcd_pkg::ADDR_RAM_HI) ram_m[a - 8'hE0] = d;
    idle(1);
  endtask

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == slcd_pkg::ADDR_MODE) return 8'(mode_m);
    if (a >= slcd_pkg::ADDR_RAM_LO && a <= slcd_pkg::ADDR_RAM_HI) return 8'(ram_m[a - 8'hE0]);
    return 8'h00;
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    bus.addr = a;
    bus.rd = 1'b1;
    idle(1);
    bus.rd = 1'b0;
    `CHK(cpu_rdata, exp_rd(a))
    idle(1);
    `CHK(cpu_rdata, 8'h00)
  endtask

  function automatic logic [47:0] row(input int b);
    for (int k = 0; k < 6; k++) row[8*k +: 8] = 8'(ram_m[6*b + k]);
  endfunction

  task automatic pulse(input bit h);
    halt_exec = h;
    wake_evt = !h;
    idle(1);
    halt_exec = 1'b0;
    wake_evt = 1'b0;
  endtask

  // Lets two invert toggles pass after the change, then times the frame that ends at the third
  task automatic frame_len(input int exp);
    int t;
    logic v;
    for (int k = 0; k < 3; k++)
    begin
      v = panel.invert;
      t = 0;
      while (panel.invert === v && t < 20000)
      begin
        idle(1);
        t++;
      end
    end
    `CHK(t, exp)
  endtask

  initial
  begin
    void'($urandom(32'h93F373AA));
    idle(8);
    reset = 1'b0;
    rd_chk(slcd_pkg::ADDR_MODE);
    `CHK(panel.on, 1'b0)
    wr(slcd_pkg::ADDR_MODE, (8'($urandom) & 8'hC7) | 8'h10);
    rd_chk(slcd_pkg::ADDR_MODE);
    wr(8'hF8, 8'h5A);
    rd_chk(8'hF8);
    rd_chk(8'hDB);
    rd_chk(8'hDD);
    for (int i = 0; i < 24; i++) wr(8'hE0 + 8'(i), 8'($urandom));
    for (int i = 0; i < 24; i++) rd_chk(8'hE0 + 8'(i));
    for (int s = 0; s < 4; s++)
    begin
      wr(8'hE0 + 8'($urandom_range(23)), 8'($urandom));
      wr(slcd_pkg::ADDR_MODE, {2'((4 - s) % 4), 6'h1E});
      idle((s == 0 ? 1 : 5 - s) * SLOT + 100);
      clr = 1'b1;
      idle(1);
      clr = 1'b0;
      idle((4 - s) * SLOT + 100);
      `CHK(seen, 4'((1 << (4 - s)) - 1))
      for (int b = 0; b < 4 - s; b++) `CHK(lit[b] & MASK, row(b) & MASK)
    end
    pulse(1'b1);
    idle(3);
    `CHK(panel, slcd_pkg::slcd_panel_s'(0))
    idle(200);
    `CHK(panel.on, 1'b0)
    pulse(1'b0);
    idle(5);
    `CHK(panel.on, 1'b1)
    aux_run = 1'b1;
    idle(50);
    wr(slcd_pkg::ADDR_MODE, 8'h4E);
    pulse(1'b1);
    idle(3);
    `CHK(panel.on, 1'b0)
    pulse(1'b0);
    idle(100);
    `CHK(panel.on, 1'b1)
    idle(2700);
    pulse(1'b1);
    clr = 1'b1;
    idle(1);
    clr = 1'b0;
    idle(2700);
    `CHK(seen, 4'h1)
    `CHK(lit[0] & MASK, row(0) & MASK)
    aux_run = 1'b0;
    idle(300);
    `CHK(panel.on, 1'b0)
    aux_run = 1'b1;
    idle(100);
    `CHK(panel.on, 1'b1)
    pulse(1'b0);
    wr(slcd_pkg::ADDR_MODE, 8'h46);
    idle(5);
    `CHK(panel.on, 1'b1)
    idle(2700);
    `CHK(panel.on, 1'b0)
    aux_run = 1'b0;
    foreach (codes[i])
    begin
      wr(slcd_pkg::ADDR_MODE, codes[i]);
      idle(10);
      `CHK(panel.on, 1'b0)
      rd_chk(slcd_pkg::ADDR_MODE);
    end
    wr(slcd_pkg::ADDR_MODE, 8'h9D);
    frame_len(6144);
    wr(slcd_pkg::ADDR_MODE, 8'h66);
    frame_len(4096);
    wr(slcd_pkg::ADDR_MODE, 8'h6E);
    wr(slcd_pkg::ADDR_MODE, 8'h76);
    rd_chk(slcd_pkg::ADDR_MODE);
    `CHK(faults, 0)
    wrap_up();
  end
endmodule // slcd_controller_tb

// ### slcd_panel_model.sv
`timescale 1ns/1ps
module slcd_panel_model (
  input  wire logic                       clk,
  input  wire slcd_pkg::slcd_panel_s      panel,
  input  wire logic                       clr,
  output logic [3:0][slcd_pkg::SEG_W-1:0] lit,
  output logic [3:0]                      seen,
  output int                              faults
);
  logic [3:0] bp_q = 4'h0;
  initial faults = 0;
  // Glass is passive; it records what each backplane last showed and counts drive faults
  always @(posedge clk)
  begin
    bp_q <= panel.bp;
    seen <= clr ? 4'h0 : seen | (panel.on === 1'b1 ? panel.bp : 4'h0);
    for (int i = 0; i < 4; i++)
      if (panel.on === 1'b1 && panel.bp[i] === 1'b1) lit[i] <= panel.seg;
    // Any level left on a dark panel would put DC across the cells
    if (panel.on === 1'b0 && panel !== '0) faults <= faults + 1;
    if (panel.on === 1'b1 && ($countones(panel.bp) != 1 || (panel.bp != bp_q && bp_q != 4'h0
        && panel.bp != 4'h1 && panel.bp != {bp_q[2:0], 1'b0}))) faults <= faults + 1;
  end
endmodule // slcd_panel_model

// ### slcd_pattern_ram.sv
`timescale 1ns/1ps
module slcd_pattern_ram (
  input  wire logic                       clk,
  input  wire logic                       wr_en,
  input  wire logic [4:0]                 cpu_idx,
  input  wire logic [7:0]                 wdata,
  output logic      [7:0]                 cpu_q_r,
  input  wire logic [1:0]                 row_sel,
  output logic      [slcd_pkg::SEG_W-1:0] row_q_r
);
  // No reset: contents are arbitrary after power-up
  logic [7:0] mem [slcd_pkg::RAM_BYTES];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[cpu_idx] <= wdata;
    cpu_q_r <= mem[cpu_idx];
  end

  // Byte k of a backplane lands on bits 8k+7..8k, LSB = lowest segment
  for (genvar k = 0; k < slcd_pkg::BYTES_PER_BP; k++)
  begin : g_row
    always_ff @(posedge clk)
    begin
      row_q_r[k*8 +: 8] <= mem[5'(row_sel) * 5'(slcd_pkg::BYTES_PER_BP) + 5'(k)];
    end
  end
endmodule // slcd_pattern_ram

// ### slcd_pkg.sv
// Functional notes
// - A set pattern bit lights its panel element; a clear bit keeps it dark.
// - Pattern memory has no reset; contents after reset are arbitrary.
// - Bytes of unused backplanes work as ordinary read/write storage.
// - Pattern memory sits at E0-F7, six bytes per backplane, backplanes one to four.
// - Segments ascend LSB to MSB; first byte's three low bits unused, S4 to S48.
// - With a main-clock source, halt switches the controller off.
// - While switched off by halt, all segment and backplane lines are grounded.
// - With the auxiliary oscillator selected, refresh continues through halt.
// - Function or clock source changes take effect only at frame end; the code applies them at once while not running.
// - Halt before a pending auxiliary switch takes effect turns the display off.
// - Source code 000 off, 001 auxiliary, 010/111 reserved, others divide main clock.
// - Mode register: mux ratio bits 7-6, source bits 5-3, frame base bits 2-0.
// - Mux ratio field sets how many backplanes are driven, one to four.
// - Frame base divides reference by 512,386,256,192,128,96,64; 111 reserved.
// - Mux code 00 four backplanes, 01 one, 10 two, 11 three.
// - Main divider codes 011/100/101/110 divide by 32/64/128/256.
// - Frame rate is base frequency divided by active backplane count.
// - On clock source failure all segment and backplane lines go to ground.
package slcd_pkg;
  localparam logic [7:0] ADDR_MODE    = 8'hDC;
  localparam logic [7:0] ADDR_RAM_LO  = 8'hE0;
  localparam logic [7:0] ADDR_RAM_HI  = 8'hF7;
  localparam int         RAM_BYTES    = 24;
  localparam int         BYTES_PER_BP = 6;
  localparam int         NUM_BP       = 4;
  localparam int         SEG_W        = 48;
  localparam logic [7:0] MODE_RESET   = 8'h00;

  localparam logic [2:0] SRC_OFF    = 3'h0;
  localparam logic [2:0] SRC_AUX    = 3'h1;
  localparam logic [2:0] SRC_RSV_A  = 3'h2;
  localparam logic [2:0] SRC_DIV32  = 3'h3;
  localparam logic [2:0] SRC_DIV64  = 3'h4;
  localparam logic [2:0] SRC_DIV128 = 3'h5;
  localparam logic [2:0] SRC_DIV256 = 3'h6;
  localparam logic [2:0] SRC_RSV_B  = 3'h7;
  localparam logic [8:0] MDIV_32    = 9'h020;
  localparam logic [8:0] MDIV_64    = 9'h040;
  localparam logic [8:0] MDIV_128   = 9'h080;
  localparam logic [8:0] MDIV_256   = 9'h100;

  localparam logic [2:0] FRM_RSV  = 3'h7;
  localparam logic [9:0] FDIV_512 = 10'h200;
  localparam logic [9:0] FDIV_386 = 10'h182;
  localparam logic [9:0] FDIV_256 = 10'h100;
  localparam logic [9:0] FDIV_192 = 10'h0C0;
  localparam logic [9:0] FDIV_128 = 10'h080;
  localparam logic [9:0] FDIV_96  = 10'h060;
  localparam logic [9:0] FDIV_64  = 10'h040;

  localparam logic [1:0] MUX_4 = 2'h0;
  localparam logic [1:0] MUX_1 = 2'h1;
  localparam logic [1:0] MUX_2 = 2'h2;
  localparam logic [1:0] MUX_3 = 2'h3;

  localparam int CLK_MHZ             = 50;
  localparam int AUX_TIMEOUT_US      = 100;
  localparam int AUX_TIMEOUT_CYC_DFLT = AUX_TIMEOUT_US * CLK_MHZ;
  localparam int IDLE_W              = 16;

  typedef struct packed {
    logic [1:0] mux;
    logic [2:0] src;
    logic [2:0] frm;
  } slcd_mode_s;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } slcd_bus_s;

  typedef struct packed {
    logic [SEG_W-1:0]  seg;
    logic [NUM_BP-1:0] bp;
    logic              invert;
    logic              on;
  } slcd_panel_s;

  typedef enum logic [2:0] {
    ST_OFF  = 3'b001,
    ST_RUN  = 3'b010,
    ST_FAIL = 3'b100
  } slcd_state_e;
endpackage
